/* File: stp_map.svh */
// offsets, field positions, reset values and timing counts of the serial transmit port
`ifndef STP_MAP_SVH
`define STP_MAP_SVH

// packet format field codes
`define STP_FMT_PACKET 2'h0
`define STP_FMT_SYNC 2'h1
`define STP_FMT_ASYNC 2'h3

// serial-mode settings that the controller programs into the device
`define STP_SYNC_MODE_NONE 3'h0
`define STP_LEN_INFINITE 2'h2
`define STP_LEN_FIXED 2'h0

// oversampling of the asynchronous input and synchronous latency in bits
`define STP_OVERSAMPLE 8
`define STP_OVERSAMPLE_LOG2 3
`define STP_SYNC_LATENCY 8

// bit period in system clock cycles
`define STP_PERIOD_RESET 16'h0040
`define STP_PERIOD_MIN 16'h0010

// controller register offsets (byte addresses)
`define STP_REG_CTRL 12'h000
`define STP_REG_PERIOD 12'h004
`define STP_REG_DATA 12'h008
`define STP_REG_STATUS 12'h00C

// control register fields
`define STP_CTRL_START 0
`define STP_CTRL_STOP 1
`define STP_CTRL_FMT_LO 2
`define STP_CTRL_FMT_HI 3

// status register fields
`define STP_STAT_ACTIVE 0
`define STP_STAT_PENDING 1
`define STP_STAT_BUSY 2

`define STP_WORD_BITS 32
`endif

/* File: stp_pkg.sv */
// types shared by both ends of the serial transmit port
package stp_pkg;
    typedef logic [1:0] stp_fmt_t;
    typedef logic [15:0] stp_period_t;
    typedef enum logic [1:0] {
        STP_ST_IDLE,
        STP_ST_RUN,
        STP_ST_DRAIN
    } stp_host_st_t;
endpackage

/* File: stp_link_if.sv */
// pins and configuration port between the transmitter and its controller
interface stp_link_if;
    // configuration port of the device
    stp_pkg::stp_fmt_t cfg_packet_format_field;
    logic [2:0] cfg_sync_mode;
    logic cfg_crc_en;
    logic [1:0] cfg_length;
    stp_pkg::stp_period_t cfg_period;
    logic tx_strobe;
    logic idle_strobe;
    // general pin zero, two-way
    logic pin0_dev_out;
    logic pin0_dev_oe_n;
    logic pin0_host_out;
    logic pin0_host_oe_n;
    logic pin0;
    // bit clock made by the device
    logic bit_clk;

    assign pin0 = !pin0_dev_oe_n ? pin0_dev_out : (!pin0_host_oe_n ? pin0_host_out : 1'b1);

    modport dev (
        input cfg_packet_format_field, cfg_sync_mode, cfg_crc_en, cfg_length, cfg_period,
        input tx_strobe, idle_strobe, pin0,
        output pin0_dev_out, pin0_dev_oe_n, bit_clk
    );
    modport host (
        output cfg_packet_format_field, cfg_sync_mode, cfg_crc_en, cfg_length, cfg_period,
        output tx_strobe, idle_strobe, pin0_host_out, pin0_host_oe_n,
        input bit_clk
    );
endinterface

/* File: stp_device.sv */
// transmitter end: serial data path from general pin zero to the modulator
// Function
// - async mode bypasses packet handling and Manchester
// - packet format 3 selects asynchronous mode
// - host programs no sync word, no CRC
// - host programs infinite packet length in async and sync modes
// - transmit strobe makes pin zero an input in async and sync modes
// - async input sampled eight times per bit
// - host keeps async bit period within one eighth
// - device drives bit clock, host follows it
// - pin zero is input while sync transmitting
// - sync bits delayed eight periods to modulator
// - host shifts words out as written, adding no preamble, sync word or CRC
`include "stp_map.svh"

module stp_device (
    // system
    input wire logic clk_sys,
    input wire logic srst,
    // link to the controller
    stp_link_if.dev link,
    // packet engine side
    input wire logic pkt_bit,
    input wire logic manch_en,
    output logic pkt_bit_take,
    // pin zero output selection while not transmitting serially
    input wire logic pin0_sel_level,
    // modulator side
    output logic mod_bit,
    output logic mod_strobe,
    output logic manch_active,
    output logic tx_active,
    output logic serial_active
);
    stp_pkg::stp_fmt_t fmt;
    logic is_async;
    logic is_sync;
    logic is_packet;
    stp_pkg::stp_period_t period;
    stp_pkg::stp_period_t samp_len;
    stp_pkg::stp_period_t bit_cnt;
    stp_pkg::stp_period_t samp_cnt;
    logic bit_tick;
    logic half_tick;
    logic samp_tick;
    logic in_s1;
    logic in_s2;
    logic in_s3;
    logic din;
    logic [`STP_SYNC_LATENCY-1:0] dly;
    logic manch_half;
    logic bclk;
    logic pin_out_q;

    assign fmt = link.cfg_packet_format_field;
    assign is_async = (fmt == `STP_FMT_ASYNC);
    assign is_sync = (fmt == `STP_FMT_SYNC);
    assign is_packet = (fmt == `STP_FMT_PACKET);
    assign serial_active = tx_active && (is_async || is_sync);

    // bit period, never below the minimum the input path can follow
    assign period = (link.cfg_period < `STP_PERIOD_MIN) ? `STP_PERIOD_MIN : link.cfg_period;
    assign samp_len = period >> `STP_OVERSAMPLE_LOG2;

    // transmit state follows the strobes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tx_active <= 1'b0;
        end else if (link.tx_strobe) begin
            tx_active <= 1'b1;
        end else if (link.idle_strobe) begin
            tx_active <= 1'b0;
        end
    end

    // pin zero: driven from its configured selection unless serial transmit owns it
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_out_q <= 1'b0;
        end else begin
            pin_out_q <= pin0_sel_level;
        end
    end

    assign link.pin0_dev_out = pin_out_q;
    // input whenever a serial transmit is running, whatever the selection says
    assign link.pin0_dev_oe_n = serial_active;

    // pin input: three flops, a change counts once the last two agree
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            in_s1 <= 1'b0;
            in_s2 <= 1'b0;
            in_s3 <= 1'b0;
        end else begin
            in_s1 <= link.pin0;
            in_s2 <= in_s1;
            in_s3 <= in_s2;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            din <= 1'b0;
        end else if (in_s2 == in_s3) begin
            din <= in_s3;
        end
    end

    // bit period counter
    always_ff @(posedge clk_sys) begin
        if (srst || !tx_active) begin
            bit_cnt <= '0;
        end else if (bit_cnt >= period - 16'h0001) begin
            bit_cnt <= '0;
        end else begin
            bit_cnt <= bit_cnt + 16'h0001;
        end
    end

    assign bit_tick = tx_active && (bit_cnt == '0);
    assign half_tick = tx_active && (bit_cnt == (period >> 1));

    // oversampling counter, eight ticks per bit period
    always_ff @(posedge clk_sys) begin
        if (srst || !tx_active) begin
            samp_cnt <= '0;
        end else if (samp_cnt >= samp_len - 16'h0001) begin
            samp_cnt <= '0;
        end else begin
            samp_cnt <= samp_cnt + 16'h0001;
        end
    end

    assign samp_tick = tx_active && is_async && (samp_cnt == '0);

    // bit clock: high for the first half of each period, only in sync transmit
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bclk <= 1'b0;
        end else if (!(tx_active && is_sync)) begin
            bclk <= 1'b0;
        end else if (bit_tick) begin
            bclk <= 1'b1;
        end else if (half_tick) begin
            bclk <= 1'b0;
        end
    end

    assign link.bit_clk = bclk;

    // sync delay line: a bit captured at a rising bit clock leaves eight periods later
    always_ff @(posedge clk_sys) begin
        if (srst || !(tx_active && is_sync)) begin
            dly <= '0;
        end else if (bit_tick) begin
            dly <= {dly[`STP_SYNC_LATENCY-2:0], din};
        end
    end

    // Manchester half tracker, runs while transmitting in any mode
    always_ff @(posedge clk_sys) begin
        if (srst || !tx_active) begin
            manch_half <= 1'b0;
        end else if (bit_tick) begin
            manch_half <= 1'b0;
        end else if (half_tick) begin
            manch_half <= 1'b1;
        end
    end

    // no Manchester outside packet mode
    assign manch_active = manch_en && is_packet;

    // modulator feed
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mod_bit <= 1'b0;
            mod_strobe <= 1'b0;
        end else begin
            mod_strobe <= 1'b0;
            if (samp_tick) begin
                // asynchronous: raw oversampled level, no packet engine involved
                mod_bit <= din;
                mod_strobe <= 1'b1;
            end else if (tx_active && is_sync && bit_tick) begin
                mod_bit <= dly[`STP_SYNC_LATENCY-1];
                mod_strobe <= 1'b1;
            end else if (tx_active && is_packet && bit_tick) begin
                mod_bit <= pkt_bit;
                mod_strobe <= 1'b1;
            end else if (tx_active && is_packet && half_tick && manch_active && !manch_half) begin
                mod_bit <= !mod_bit;
                mod_strobe <= 1'b1;
            end
        end
    end

    // packet engine only advances in packet mode
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pkt_bit_take <= 1'b0;
        end else begin
            pkt_bit_take <= tx_active && is_packet && bit_tick;
        end
    end
endmodule

/* File: stp_host.sv */
// controller end: APB registers, word feed onto pin zero in async or sync serial mode
`include "stp_map.svh"

module stp_host (
    // system
    input wire logic clk_sys,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link to the transmitter
    stp_link_if.host link
);
    stp_pkg::stp_host_st_t state;
    stp_pkg::stp_fmt_t fmt;
    stp_pkg::stp_period_t period;
    logic [31:0] word_buf;
    logic pending;
    logic req_t;
    logic ack_s1;
    logic ack_s2;
    logic wr;
    logic rd_ok;
    logic is_sync;
    logic serial;
    logic [31:0] a_sh;
    logic [5:0] a_cnt;
    stp_pkg::stp_period_t a_tim;
    logic a_bit;
    logic strobe_q;
    logic idle_q;
    // link domain
    logic l_req1;
    logic l_req2;
    logic l_ack_t;
    logic [31:0] l_sh;
    logic [5:0] l_cnt;
    logic l_bit;

    assign is_sync = (fmt == `STP_FMT_SYNC);
    assign serial = (fmt == `STP_FMT_SYNC) || (fmt == `STP_FMT_ASYNC);
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign rd_ok = (paddr == `STP_REG_CTRL) || (paddr == `STP_REG_PERIOD)
        || (paddr == `STP_REG_STATUS) || (paddr == `STP_REG_DATA);
    // unmapped address, or data written while a word still waits
    assign pslverr = psel && penable && (!rd_ok || (pwrite && paddr == `STP_REG_DATA && pending));

    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            `STP_REG_CTRL: prdata[`STP_CTRL_FMT_HI:`STP_CTRL_FMT_LO] = fmt;
            `STP_REG_PERIOD: prdata[15:0] = period;
            `STP_REG_DATA: prdata = word_buf;
            `STP_REG_STATUS: begin
                prdata[`STP_STAT_ACTIVE] = (state != stp_pkg::STP_ST_IDLE);
                prdata[`STP_STAT_PENDING] = pending;
                prdata[`STP_STAT_BUSY] = (state == stp_pkg::STP_ST_DRAIN);
            end
            default: prdata = 32'h0000_0000;
        endcase
    end

    // configuration registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fmt <= `STP_FMT_PACKET;
            period <= `STP_PERIOD_RESET;
        end else if (wr && paddr == `STP_REG_CTRL && state == stp_pkg::STP_ST_IDLE) begin
            fmt <= pwdata[`STP_CTRL_FMT_HI:`STP_CTRL_FMT_LO];
        end else if (wr && paddr == `STP_REG_PERIOD && state == stp_pkg::STP_ST_IDLE) begin
            period <= pwdata[15:0];
        end
    end

    // serial modes get no sync word, no CRC, infinite length; stream carries its own
    assign link.cfg_packet_format_field = fmt;
    assign link.cfg_sync_mode = `STP_SYNC_MODE_NONE;
    assign link.cfg_crc_en = 1'b0;
    assign link.cfg_length = serial ? `STP_LEN_INFINITE : `STP_LEN_FIXED;
    assign link.cfg_period = period;
    assign link.tx_strobe = strobe_q;
    assign link.idle_strobe = idle_q;

    // run state and strobes to the transmitter
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= stp_pkg::STP_ST_IDLE;
            strobe_q <= 1'b0;
            idle_q <= 1'b0;
        end else begin
            strobe_q <= 1'b0;
            idle_q <= 1'b0;
            case (state)
                stp_pkg::STP_ST_IDLE: begin
                    if (wr && paddr == `STP_REG_CTRL && pwdata[`STP_CTRL_START]) begin
                        state <= stp_pkg::STP_ST_RUN;
                        strobe_q <= 1'b1;
                    end
                end
                stp_pkg::STP_ST_RUN: begin
                    if (wr && paddr == `STP_REG_CTRL && pwdata[`STP_CTRL_STOP]) begin
                        state <= stp_pkg::STP_ST_DRAIN;
                    end
                end
                stp_pkg::STP_ST_DRAIN: begin
                    if (!pending) begin
                        state <= stp_pkg::STP_ST_IDLE;
                        idle_q <= 1'b1;
                    end
                end
                default: state <= stp_pkg::STP_ST_IDLE;
            endcase
        end
    end

    // one word buffer, handed to whichever path shifts it out
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            word_buf <= 32'h0000_0000;
            req_t <= 1'b0;
        end else if (wr && paddr == `STP_REG_DATA && !pending) begin
            word_buf <= pwdata;
            req_t <= is_sync ? !req_t : req_t;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= l_ack_t;
            ack_s2 <= ack_s1;
        end
    end

    // pending clears when the async path loads it or the link side acknowledges
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pending <= 1'b0;
        end else if (wr && paddr == `STP_REG_DATA && !pending) begin
            pending <= 1'b1;
        end else if (is_sync && pending && ack_s2 == req_t) begin
            pending <= 1'b0;
        end else if (!is_sync && a_cnt == 6'h00 && a_tim == '0 && state != stp_pkg::STP_ST_IDLE) begin
            pending <= 1'b0;
        end
    end

    // async path: bit period timed exactly from the programmed period
    always_ff @(posedge clk_sys) begin
        if (srst || state == stp_pkg::STP_ST_IDLE || is_sync) begin
            a_sh <= 32'h0000_0000;
            a_cnt <= 6'h00;
            a_tim <= '0;
            a_bit <= 1'b0;
        end else if (a_tim != '0) begin
            a_tim <= a_tim - 16'h0001;
        end else begin
            a_tim <= period - 16'h0001;
            if (a_cnt != 6'h00) begin
                a_bit <= a_sh[31];
                a_sh <= {a_sh[30:0], 1'b0};
                a_cnt <= a_cnt - 6'h01;
            end else if (pending) begin
                a_bit <= word_buf[31];
                a_sh <= {word_buf[30:0], 1'b0};
                a_cnt <= 6'(`STP_WORD_BITS - 1);
            end else begin
                a_bit <= 1'b0;
            end
        end
    end

    // sync path: runs on the bit clock, new data set up at its falling edge
    // the bit clock stands still in reset, so the link side clears on the reset level
    always_ff @(negedge link.bit_clk or posedge srst) begin
        if (srst) begin
            l_req1 <= 1'b0;
            l_req2 <= 1'b0;
        end else begin
            l_req1 <= req_t;
            l_req2 <= l_req1;
        end
    end

    always_ff @(negedge link.bit_clk or posedge srst) begin
        if (srst) begin
            l_bit <= 1'b0;
            l_sh <= 32'h0000_0000;
            l_cnt <= 6'h00;
            l_ack_t <= 1'b0;
        end else if (l_cnt != 6'h00 && l_cnt <= 6'(`STP_WORD_BITS)) begin
            l_bit <= l_sh[31];
            l_sh <= {l_sh[30:0], 1'b0};
            l_cnt <= l_cnt - 6'h01;
        end else if (l_req2 != l_ack_t) begin
            l_bit <= word_buf[31];
            l_sh <= {word_buf[30:0], 1'b0};
            l_cnt <= 6'(`STP_WORD_BITS - 1);
            l_ack_t <= l_req2;
        end else begin
            l_bit <= 1'b0;
            l_cnt <= 6'h00;
        end
    end

    // host drives pin zero only while a serial transmit runs
    assign link.pin0_host_out = is_sync ? l_bit : a_bit;
    assign link.pin0_host_oe_n = !(serial && state != stp_pkg::STP_ST_IDLE);
endmodule

/* File: stp_link_asserts.sv */
// concurrent checks on the link between the transmitter and its controller
module stp_link_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // link signals
    input wire stp_pkg::stp_fmt_t cfg_packet_format_field,
    input wire logic [2:0] cfg_sync_mode,
    input wire logic cfg_crc_en,
    input wire logic [1:0] cfg_length,
    input wire stp_pkg::stp_period_t cfg_period,
    input wire logic tx_strobe,
    input wire logic pin0_dev_oe_n,
    input wire logic pin0_host_oe_n,
    input wire logic bit_clk,
    // device outputs
    input wire logic mod_strobe,
    input wire logic manch_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_sync_cfg_clean: assert property (cfg_sync_mode == 3'h0 && !cfg_crc_en)
        else $error("sync word or crc enabled");
    a_len_infinite: assert property (cfg_packet_format_field[0] |-> cfg_length == 2'h2)
        else $error("serial mode without infinite length");
    a_strobe_frees_pin: assert property (tx_strobe && cfg_packet_format_field[0] |-> ##[1:3] pin0_dev_oe_n)
        else $error("pin zero still driven after start");
    a_clock_sync_only: assert property (bit_clk |-> cfg_packet_format_field == 2'h1)
        else $error("bit clock outside sync mode");
    a_pin_input_tx: assert property ($rose(bit_clk) |-> pin0_dev_oe_n && !pin0_host_oe_n)
        else $error("pin zero not an input during sync transmit");
    a_async_quiet: assert property (cfg_packet_format_field == 2'h3 |-> !bit_clk && !manch_active)
        else $error("clock or manchester in async mode");
    a_async_rate: assert property (mod_strobe && cfg_packet_format_field == 2'h3
        && cfg_period == 16'h0040 |=> !mod_strobe [*7])
        else $error("async samples closer than an eighth bit");
    a_pkt_drives_pin: assert property (cfg_packet_format_field == 2'h0 |-> !pin0_dev_oe_n)
        else $error("pin zero released in packet mode");
endmodule

/* File: serial_tx_data_port_tb.sv */
// testbench joining controller and transmitter over the link
module serial_tx_data_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic wr; logic [11:0] addr; logic [31:0] wd, rd; logic err;} stp_row_t;
    logic clk_sys = 1'b0, srst, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, got;
    logic pready, pslverr, err, pkt_bit = 1'b0, manch_en = 1'b1, pin0_sel_level = 1'b0;
    logic mod_bit, mod_strobe, manch_active, pkt_take, tx_act, ser_act;
    int fails = 0, tests_run = 0, lat;
    stp_row_t rows [9] = '{
        '{1'b0, 12'h004, 32'h0000_0000, 32'h0000_0040, 1'b0},
        '{1'b0, 12'h00C, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, 12'h010, 32'h0000_0000, 32'h0000_0000, 1'b1},
        '{1'b1, 12'h004, 32'h0000_0020, 32'h0000_0000, 1'b0},
        '{1'b0, 12'h004, 32'h0000_0000, 32'h0000_0020, 1'b0},
        '{1'b1, 12'h004, 32'h0000_0040, 32'h0000_0000, 1'b0},
        '{1'b1, 12'h000, 32'h0000_000C, 32'h0000_0000, 1'b0},
        '{1'b0, 12'h000, 32'h0000_0000, 32'h0000_000C, 1'b0},
        '{1'b1, 12'h000, 32'h0000_0000, 32'h0000_0000, 1'b0}};

    stp_link_if link ();
    stp_host i_stp_host (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    stp_device i_stp_device (.clk_sys(clk_sys), .srst(srst), .link(link), .pkt_bit(pkt_bit),
        .manch_en(manch_en), .pkt_bit_take(pkt_take), .pin0_sel_level(pin0_sel_level),
        .mod_bit(mod_bit), .mod_strobe(mod_strobe), .manch_active(manch_active),
        .tx_active(tx_act), .serial_active(ser_act));
    stp_link_asserts i_stp_link_asserts (.clk_sys(clk_sys), .srst(srst),
        .cfg_packet_format_field(link.cfg_packet_format_field), .cfg_sync_mode(link.cfg_sync_mode),
        .cfg_crc_en(link.cfg_crc_en), .cfg_length(link.cfg_length),
        .cfg_period(link.cfg_period), .tx_strobe(link.tx_strobe),
        .pin0_dev_oe_n(link.pin0_dev_oe_n), .pin0_host_oe_n(link.pin0_host_oe_n),
        .bit_clk(link.bit_clk), .mod_strobe(mod_strobe), .manch_active(manch_active));

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // one apb transfer, held until pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // gathers 32 bits from the modulator, starting at the first one bit
    task collect(input logic sync, output logic [31:0] w, output int dt);
        int k, n, t0;
        logic pc;
        k = -1;
        n = 0;
        t0 = -1;
        pc = 1'b0;
        w = 32'h0000_0000;
        dt = 0;
        for (int c = 0; c < 6000 && n < 32; c++) begin
            @(posedge clk_sys);
            if (link.bit_clk === 1'b1 && pc !== 1'b1 && link.pin0 === 1'b1 && t0 < 0) t0 = c;
            pc = link.bit_clk;
            if (mod_strobe === 1'b1 && (k >= 0 || mod_bit === 1'b1)) begin
                k++;
                if (k == 0) dt = c - t0;
                if (sync || k % 8 == 4) begin
                    w = {w[30:0], mod_bit};
                    n++;
                end
            end
        end
    endtask

    initial begin
        srst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wd);
            check("apb error", {31'h0, err}, {31'h0, rows[i].err});
            if (!rows[i].wr) check("apb read", rd, rows[i].rd);
        end
        @(posedge clk_sys);
        check("packet manchester", {31'h0, manch_active}, 32'h0000_0001);
        apb(1'b1, 12'h000, 32'h0000_000C);
        apb(1'b1, 12'h008, 32'hA5C3_0F96);
        apb(1'b1, 12'h000, 32'h0000_000D);
        repeat (4) @(posedge clk_sys);
        check("async manchester", {31'h0, manch_active}, 32'h0000_0000);
        check("pin released", {31'h0, link.pin0_dev_oe_n}, 32'h0000_0001);
        check("serial active", {31'h0, ser_act}, 32'h0000_0001);
        collect(1'b0, got, lat);
        check("async word", got, 32'hA5C3_0F96);
        apb(1'b1, 12'h000, 32'h0000_000E);
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, 12'h00C, 32'h0000_0000);
            if (rd[2:0] === 3'h0) break;
        end
        check("async stopped", rd, 32'h0000_0000);
        apb(1'b1, 12'h000, 32'h0000_0004);
        apb(1'b1, 12'h000, 32'h0000_0005);
        apb(1'b1, 12'h008, 32'hB38F_0E1D);
        apb(1'b1, 12'h008, 32'h0000_0000);
        check("data refused", {31'h0, err}, 32'h0000_0001);
        apb(1'b1, 12'h004, 32'h0000_0020);
        apb(1'b0, 12'h004, 32'h0000_0000);
        check("period held", rd, 32'h0000_0040);
        collect(1'b1, got, lat);
        check("sync word", got, 32'hB38F_0E1D);
        check("sync latency", (lat + 8) / 64, 32'h0000_0008);
        srst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        check("clock stopped", {31'h0, link.bit_clk}, 32'h0000_0000);
        check("pin driven", {31'h0, link.pin0_dev_oe_n}, 32'h0000_0000);
        apb(1'b0, 12'h004, 32'h0000_0000);
        check("period reset", rd, 32'h0000_0040);
        apb(1'b1, 12'h000, 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        check("packet take", {31'h0, pkt_take}, 32'h0000_0001);
        check("packet tx active", {31'h0, tx_act}, 32'h0000_0001);
        check("packet not serial", {31'h0, ser_act}, 32'h0000_0000);
        give_verdict;
    end

    initial begin
        #100000;
        fails++;
        give_verdict;
    end
endmodule
